// ---- dcsm_word_map.sv ----
// control word decoder and status word builder with a wishbone register slave
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dcsm_map.svh"
module dcsm_word_map (
  // clock and reset
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RST_B,
  // wishbone slave
  input  wire logic                I_WB_CYC,
  input  wire logic                I_WB_STB,
  input  wire logic                I_WB_WE,
  input  wire logic [7:0]          I_WB_ADR,
  input  wire logic [3:0]          I_WB_SEL,
  input  wire logic [31:0]         I_WB_DAT,
  output var  logic [31:0]         O_WB_DAT,
  output logic                     O_WB_ACK,
  // drive core
  input  wire dcsm_pkg::dcsm_drv_t I_DRV,
  input  wire logic [15:0]         I_OUT_FREQ,
  input  wire logic                I_OUT_NEG,
  input  wire logic [15:0]         I_OUT_CURRENT,
  // digital input pins
  input  wire logic [4:0]          I_DIN,
  // drive commands
  output var  dcsm_pkg::dcsm_cmd_t O_CMD,
  output var  logic [15:0]         O_FREQ_CMD,
  output var  logic                O_RELAY
);
  // ****************************************************************
  // functions
  // ****************************************************************
  // magnitude in hz to signed word, 16384 is the full span
  function automatic logic [15:0] span_scale(input logic [15:0] f, input logic [15:0] lo,
                                             input logic [15:0] hi);
    logic [31:0] num;
    logic [31:0] q;
    num = 32'h0;
    q   = 32'h0;
    if (hi > lo) begin
      num = (f > lo) ? ({16'h0, f - lo} << 14) : 32'h0;
      q   = num / {16'h0, hi - lo};
    end
    span_scale = (q > {16'h0, `DCSM_SCALE_MAX}) ? `DCSM_SCALE_MAX : q[15:0];
  endfunction : span_scale

  function automatic logic [15:0] neg16(input logic [15:0] v);
    neg16 = (~v) + 16'h0001;
  endfunction : neg16

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  logic [15:0] ctrl_word;
  logic [15:0] speed_ref;
  logic [2:0]  cfg;
  logic [15:0] jog1_freq;
  logic [15:0] jog2_freq;
  logic [15:0] ref_offset;
  logic [15:0] freq_low;
  logic [15:0] freq_high;
  logic [15:0] ref_min;
  logic [15:0] ref_max;
  logic [15:0] current_limit_setting;
  logic [15:0] trip_time;
  logic [15:0] status_word;
  logic [15:0] out_freq_word;

  wire         bus_req  = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire         bus_wr   = bus_req & I_WB_WE;
  wire [5:0]   reg_idx  = I_WB_ADR[7:2];
  wire [15:0]  wr_data  = I_WB_DAT[15:0];
  wire         wr_lanes = I_WB_SEL[1] & I_WB_SEL[0];
  wire         wr_ok    = bus_wr & wr_lanes;
  wire         wr_ctrl  = wr_ok & (reg_idx == `DCSM_OFS_CTRL);
  wire         wr_ref   = wr_ok & (reg_idx == `DCSM_OFS_SPEED_REF);
  wire         serial_ok = ~I_DRV.local_key & ~I_DRV.local_mode;
  wire         ctrl_take = wr_ctrl & wr_data[`DCSM_CW_VALID] & serial_ok;
  wire         ref_take  = wr_ref & serial_ok;
  dcsm_pkg::dcsm_prof_t prof;
  assign prof = dcsm_pkg::dcsm_prof_t'(cfg[1:0]);
  wire         relay_fn = cfg[`DCSM_CFG_RELAY];

  logic [15:0] rd_mux;
  dcsm_pkg::dcsm_cmd_t next_cmd;
  always_comb begin
    case (reg_idx)
      `DCSM_OFS_CTRL:      rd_mux = ctrl_word;
      `DCSM_OFS_STATUS:    rd_mux = status_word;
      `DCSM_OFS_SPEED_REF: rd_mux = speed_ref;
      `DCSM_OFS_OUT_FREQ:  rd_mux = out_freq_word;
      `DCSM_OFS_CONFIG:    rd_mux = {13'h0, cfg};
      `DCSM_OFS_JOG1:      rd_mux = jog1_freq;
      `DCSM_OFS_JOG2:      rd_mux = jog2_freq;
      `DCSM_OFS_OFFSET:    rd_mux = ref_offset;
      `DCSM_OFS_FREQ_LOW:  rd_mux = freq_low;
      `DCSM_OFS_FREQ_HIGH: rd_mux = freq_high;
      `DCSM_OFS_REF_MIN:   rd_mux = ref_min;
      `DCSM_OFS_REF_MAX:   rd_mux = ref_max;
      `DCSM_OFS_CUR_LIM:   rd_mux = current_limit_setting;
      `DCSM_OFS_TRIP_TIME: rd_mux = trip_time;
      `DCSM_OFS_CMD:       rd_mux = {3'h0, O_CMD};
      default:             rd_mux = 16'h0000;
    endcase
  end

  // unmapped addresses ack with zero data, writes there are dropped
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
    end else begin
      O_WB_ACK <= bus_req;
      O_WB_DAT <= bus_req ? {16'h0, rd_mux} : 32'h0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_word             <= 16'h0000;
      speed_ref             <= 16'h0000;
      cfg                   <= `DCSM_CFG_RST;
      jog1_freq             <= 16'h0000;
      jog2_freq             <= 16'h0000;
      ref_offset            <= 16'h0000;
      freq_low              <= 16'h0000;
      freq_high             <= 16'h0000;
      ref_min               <= 16'h0000;
      ref_max               <= 16'h0000;
      current_limit_setting <= `DCSM_CUR_LIM_RST;
      trip_time             <= `DCSM_TRIP_TIME_RST;
    end else begin
      if (ctrl_take) ctrl_word <= wr_data;
      if (ref_take) speed_ref <= wr_data;
      if (wr_ok) begin
        case (reg_idx)
          `DCSM_OFS_CONFIG:    cfg                   <= wr_data[2:0];
          `DCSM_OFS_JOG1:      jog1_freq             <= wr_data;
          `DCSM_OFS_JOG2:      jog2_freq             <= wr_data;
          `DCSM_OFS_OFFSET:    ref_offset            <= wr_data;
          `DCSM_OFS_FREQ_LOW:  freq_low              <= wr_data;
          `DCSM_OFS_FREQ_HIGH: freq_high             <= wr_data;
          `DCSM_OFS_REF_MIN:   ref_min               <= wr_data;
          `DCSM_OFS_REF_MAX:   ref_max               <= wr_data;
          `DCSM_OFS_CUR_LIM:   current_limit_setting <= wr_data;
          `DCSM_OFS_TRIP_TIME: trip_time             <= wr_data;
          default:             trip_time             <= trip_time;
        endcase
      end
    end
  end

  // ****************************************************************
  // digital input synchroniser
  // ****************************************************************
  logic [4:0] din_meta;
  logic [4:0] din_sync;
  // two cycles, far inside the response time
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      din_meta <= 5'h00;
      din_sync <= 5'h00;
    end else begin
      din_meta <= I_DIN;
      din_sync <= din_meta;
    end
  end

  // ****************************************************************
  // trip, current limit and start disable
  // ****************************************************************
  logic        trip;
  logic        start_dis;
  logic        stop_seen;
  logic [15:0] lim_cnt;
  wire         alt      = (prof == dcsm_pkg::DCSM_PROF_ALT);
  wire         over_cur = I_OUT_CURRENT > current_limit_setting;
  // rising edge only, compared with the previous accepted word
  wire         trip_rst = ctrl_take & wr_data[`DCSM_CW_RESET] & ~ctrl_word[`DCSM_CW_RESET];
  wire         cur_trip = over_cur & (lim_cnt >= trip_time);
  wire         off23    = ~ctrl_word[1] | ~ctrl_word[2];
  wire         sd_clear = ~ctrl_word[0] & ctrl_word[1] & ctrl_word[2] & ctrl_word[10];
  wire         freq_zero = (I_OUT_FREQ == 16'h0000);

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lim_cnt <= 16'h0000;
    end else begin
      lim_cnt <= over_cur ? ((lim_cnt == 16'hFFFF) ? lim_cnt : lim_cnt + 16'h0001) : 16'h0000;
    end
  end

  // a trip event in the reset cycle wins over the reset
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      trip <= 1'b0;
    end else if (I_DRV.trip_ext | cur_trip) begin
      trip <= 1'b1;
    end else if (trip_rst & ~I_DRV.trip_lock) begin
      trip <= 1'b0;
    end
  end

  // power-up sets it, set wins over clear
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      start_dis <= 1'b1;
    end else if (trip_rst | off23) begin
      start_dis <= 1'b1;
    end else if (sd_clear) begin
      start_dis <= 1'b0;
    end
  end

  // remember the stop until a start
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      stop_seen <= 1'b0;
    end else if (alt & ~(&ctrl_word[2:0])) begin
      stop_seen <= 1'b1;
    end else if (next_cmd.start) begin
      stop_seen <= 1'b0;
    end
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  // alternative profile ramp stop on any OFF
  wire         on123   = &ctrl_word[2:0];
  wire         can_run = serial_ok & ~trip & ctrl_word[3] & ctrl_word[6];
  // same profile for decode and status
  always_comb begin
    next_cmd            = '0;
    next_cmd.coast      = ~ctrl_word[3];
    next_cmd.quick_stop = ~ctrl_word[4];
    next_cmd.freeze     = ~ctrl_word[5];
    next_cmd.ramp2      = ctrl_word[9];
    next_cmd.setup      = ctrl_word[14:13];
    next_cmd.trip       = trip;
    next_cmd.jog1       = ctrl_word[8];
    if (alt) begin
      next_cmd.start     = can_run & on123 & ~start_dis;
      next_cmd.ramp_stop = ~on123 | ~ctrl_word[6];
      next_cmd.jog2      = ctrl_word[9];
      next_cmd.ramp2     = 1'b0;
    end else begin
      next_cmd.start     = can_run & ctrl_word[2] & ctrl_word[4];
      next_cmd.ramp_stop = ~ctrl_word[6];
      next_cmd.dc_brake  = ~ctrl_word[2];
    end
    next_cmd.reverse = ctrl_word[15] | speed_ref[15];
  end

  // ****************************************************************
  // reference and frequency scaling
  // ****************************************************************
  // signed magnitude, -32768 clamps to 7FFF
  wire [15:0] ref_abs  = speed_ref[15] ? neg16(speed_ref) : speed_ref;
  wire [15:0] ref_mag  = ref_abs[15] ? `DCSM_SCALE_MAX : ref_abs;
  wire [16:0] ref_up   = {1'b0, ref_mag} + {1'b0, ref_offset};
  wire [15:0] ref_adj  = (alt & ctrl_word[11]) ? ((ref_mag > ref_offset) ? ref_mag - ref_offset : 16'h0000) :
                         (alt & ctrl_word[12]) ? ((ref_up > {1'b0, `DCSM_SCALE_MAX}) ? `DCSM_SCALE_MAX
                                                                                     : ref_up[15:0]) :
                         ref_mag;
  wire [15:0] ref_span = (ref_max > ref_min) ? ref_max - ref_min : 16'h0000;
  wire [31:0] ref_prod = {16'h0, ref_adj} * {16'h0, ref_span};
  wire [31:0] ref_hz   = {16'h0, ref_min} + (ref_prod >> 14);
  wire [15:0] ref_freq = (ref_hz[31:16] != 16'h0) ? 16'hFFFF : ref_hz[15:0];
  wire [15:0] next_freq_cmd = next_cmd.jog1 ? jog1_freq :
                              next_cmd.jog2 ? jog2_freq : ref_freq;
  // limit span scaling, sign from direction
  wire [15:0] out_mag  = span_scale(I_OUT_FREQ, freq_low, freq_high);
  wire [15:0] next_out_word = I_OUT_NEG ? neg16(out_mag) : out_mag;

  // ****************************************************************
  // status word
  // ****************************************************************
  // inside the limits
  wire in_band = (I_OUT_FREQ > freq_low) & (I_OUT_FREQ < freq_high);
  wire running = next_cmd.start | ~freq_zero;
  wire warn    = I_DRV.volt_low | I_DRV.volt_high | over_cur | I_DRV.temp_motor | I_DRV.temp_conv |
                 I_DRV.thermistor;
  logic [15:0] next_status;
  always_comb begin
    next_status     = 16'h0000;
    next_status[0]  = I_DRV.ready;
    next_status[1]  = I_DRV.drive_ready;
    next_status[2]  = ctrl_word[3];
    next_status[3]  = trip;
    next_status[6]  = I_DRV.trip_lock;
    next_status[7]  = warn;
    next_status[8]  = I_DRV.at_speed;
    next_status[9]  = serial_ok;
    next_status[10] = in_band;
    next_status[11] = running;
    next_status[13] = I_DRV.volt_low | I_DRV.volt_high;
    next_status[14] = over_cur;
    next_status[15] = I_DRV.temp_motor | I_DRV.temp_conv | I_DRV.thermistor;
    case (prof)
      dcsm_pkg::DCSM_PROF_FASTIO: begin
        next_status[5]  = din_sync[0];
        next_status[12] = din_sync[1];
        next_status[13] = din_sync[2];
        next_status[14] = din_sync[3];
        next_status[15] = din_sync[4];
      end
      dcsm_pkg::DCSM_PROF_ALT: begin
        next_status[0] = I_DRV.ready & on123;
        next_status[2] = on123 & ctrl_word[3] & ~trip;
        next_status[4] = ~ctrl_word[1];
        next_status[5] = ~ctrl_word[2];
        next_status[6] = start_dis;
      end
      default: next_status[4] = 1'b0;
    endcase
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      status_word   <= 16'h0000;
      out_freq_word <= 16'h0000;
      O_CMD         <= '0;
      O_FREQ_CMD    <= 16'h0000;
      O_RELAY       <= 1'b0;
    end else begin
      status_word   <= next_status;
      out_freq_word <= next_out_word;
      O_CMD         <= next_cmd;
      O_FREQ_CMD    <= next_freq_cmd;
      O_RELAY       <= relay_fn & alt & stop_seen & freq_zero;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  invalid_word_a: assert property (wr_ctrl & ~wr_data[`DCSM_CW_VALID] |=> $stable(ctrl_word))
    else $error("control word changed without data valid");
  local_refuse_a: assert property (wr_ctrl & ~serial_ok |=> $stable(ctrl_word) && !status_word[9])
    else $error("control accepted in local operation");
  reset_edge_a: assert property (trip & ctrl_word[`DCSM_CW_RESET] |=> trip)
    else $error("trip cleared without rising reset edge");
  cur_bit_a: assert property (over_cur & (prof != dcsm_pkg::DCSM_PROF_FASTIO)
                              ##1 (prof != dcsm_pkg::DCSM_PROF_FASTIO) |-> status_word[14])
    else $error("current limit bit not set");
  start_dis_a: assert property (ctrl_take & ~wr_data[1] |=> ##1 start_dis)
    else $error("start disable not set after OFF2");
  off_stop_a: assert property (alt & ~on123 ##1 alt |-> !O_CMD.start)
    else $error("start with an OFF bit low");
  slow_prio_a: assert property (alt & ctrl_word[11] & ctrl_word[12] |-> ref_adj <= ref_mag)
    else $error("catch-up applied with slow-down");
  // inputs reach status in three cycles
  fast_io_a: assert property ((prof == dcsm_pkg::DCSM_PROF_FASTIO) [*4]
                              |-> status_word[5] == $past(I_DIN[0], 3))
    else $error("fast input level wrong");
  inv_bits_a: assert property (alt ##1 alt |-> status_word[4] == $past(~ctrl_word[1]))
    else $error("status 04 not inverse of control 01");
  bus_ack_a: assert property (bus_req |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("bus ack not one cycle");
endmodule : dcsm_word_map
`default_nettype wire

// ---- dcsm_map.svh ----
// register offsets, field positions, reset values and timing counts of the drive word map
// Summary of operation
// - status bit 08 is one while actual speed equals the active reference.
// - status bit 09 clear and serial control refused under local key or mode.
// - status bit 10 clear when output frequency reaches the low or high limit.
// - status bit 11 set on start command or output frequency above zero.
// - status bit 13 set when link voltage is below or above its band.
// - status bit 14 set above current limit; trip after configured time there.
// - status bit 15 set on motor, converter or thermistor overtemperature.
// - fast I/O layout puts raw input levels into bits 05, 12 to 15.
// - input change reaches the fast I/O status word within about ten milliseconds.
// - alternative profile ramps to stop if control bit 00, 01 or 02 is zero.
// - relay energises at zero output frequency after an alternative-profile stop.
// - control bit 08 selects bus jog frequency one, bit 09 jog two in the alternative profile.
// - in the alternative profile control bit 11 lowers, bit 12 raises the reference by the offset.
// - with bits 11 and 12 both one only the reduction applies.
// - alternative status bit 00 set only when bits 00-02 one and ready.
// - alternative status bit 02 set only when bits 00-03 one, no trip.
// - alternative status bits 04 and 05 are inverted control bits 01 and 02.
// - start-disable bit 06 set on trip reset, OFF2/OFF3, power-up; cleared specially.
// - speed reference is signed 16 bit, 16384 is 100 percent of span.
// - a negative reference reverses rotation with the same magnitude scaling.
// - output frequency reported signed, 16384 is 100 percent of limit span.
// - a control word with data-valid bit 10 at zero is ignored whole.
// - a trip resets only on a rising edge of control bit 07.
`ifndef DCSM_MAP_SVH
`define DCSM_MAP_SVH
// ****************************************************************
// register word offsets (byte address bits 7 to 2)
// ****************************************************************
`define DCSM_OFS_CTRL      6'h00
`define DCSM_OFS_STATUS    6'h01
`define DCSM_OFS_SPEED_REF 6'h02
`define DCSM_OFS_OUT_FREQ  6'h03
`define DCSM_OFS_CONFIG    6'h04
`define DCSM_OFS_JOG1      6'h05
`define DCSM_OFS_JOG2      6'h06
`define DCSM_OFS_OFFSET    6'h07
`define DCSM_OFS_FREQ_LOW  6'h08
`define DCSM_OFS_FREQ_HIGH 6'h09
`define DCSM_OFS_REF_MIN   6'h0A
`define DCSM_OFS_REF_MAX   6'h0B
`define DCSM_OFS_CUR_LIM   6'h0C
`define DCSM_OFS_TRIP_TIME 6'h0D
`define DCSM_OFS_CMD       6'h0E
// ****************************************************************
// field positions and values
// ****************************************************************
`define DCSM_CW_VALID      10
`define DCSM_CW_RESET      7
`define DCSM_CFG_RELAY     2
`define DCSM_SCALE_FULL    17'h04000
`define DCSM_SCALE_MAX     16'h7FFF
`define DCSM_CFG_RST       3'h1
`define DCSM_TRIP_TIME_RST 16'h03E8
`define DCSM_CUR_LIM_RST   16'hFFFF
// ****************************************************************
// timing
// ****************************************************************
`define DCSM_CLK_NS        100
`define DCSM_DIN_RESP_NS   10000000
`define DCSM_DIN_RESP_CYC  (`DCSM_DIN_RESP_NS / `DCSM_CLK_NS)
`endif

// ---- dcsm_pkg.sv ----
// types shared by the drive control and status word map
package dcsm_pkg;
  typedef enum logic [1:0] {
    DCSM_PROF_ALT,
    DCSM_PROF_STD,
    DCSM_PROF_FASTIO,
    DCSM_PROF_RSVD
  } dcsm_prof_t;

  // drive core state, same clock domain
  typedef struct packed {
    logic ready;
    logic drive_ready;
    logic trip_ext;
    logic trip_lock;
    logic at_speed;
    logic volt_low;
    logic volt_high;
    logic temp_motor;
    logic temp_conv;
    logic thermistor;
    logic local_key;
    logic local_mode;
  } dcsm_drv_t;

  // decoded drive commands
  typedef struct packed {
    logic       start;
    logic       ramp_stop;
    logic       coast;
    logic       quick_stop;
    logic       dc_brake;
    logic       freeze;
    logic       reverse;
    logic       jog1;
    logic       jog2;
    logic       ramp2;
    logic [1:0] setup;
    logic       trip;
  } dcsm_cmd_t;
endpackage : dcsm_pkg

// ---- dcsm_wb_master.sv ----
// wishbone classic master model for the word map
`timescale 1ns/100ps
`default_nettype none
module dcsm_wb_master (
  // bus
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  output var  logic        o_cyc,
  output var  logic        o_we,
  output var  logic [7:0]  o_adr,
  output var  logic [31:0] o_dat,
  output var  logic        o_tmo
);
  // ****************
  // one classic cycle, held until ack or until 20 more cycles pass without it
  // ****************
  initial begin
    o_cyc = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_dat = 32'h00000000;
    o_tmo = 1'b0;
  end
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_dat <= {16'h0000, wd};
    @(posedge i_clk);
    while (i_ack !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    rd = i_dat[15:0];
    if (n == 20) o_tmo <= 1'b1;
    o_cyc <= 1'b0;
  endtask : xfer
endmodule : dcsm_wb_master
`default_nettype wire

// ---- drive_control_status_word_map_test.sv ----
// self-checking bench for the drive word map
`timescale 1ns/100ps
`default_nettype none
module drive_control_status_word_map_test;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                cyc, we, ack, tmo, relay;
  logic [7:0]          adr;
  logic [31:0]         wdat, rdat;
  dcsm_pkg::dcsm_drv_t drv = '0;
  dcsm_pkg::dcsm_cmd_t cmd;
  logic [15:0]         ofreq = 16'h0000;
  logic [15:0]         cur = 16'h0000;
  logic                oneg = 1'b0;
  logic [4:0]          din = 5'h00;
  logic [15:0]         fcmd, st;
  int                  n_fail = 0;
  int                  comparisons = 0;
  always #50 clk = ~clk;
  dcsm_wb_master i_master (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_we(we), .o_adr(adr),
    .o_dat(wdat), .o_tmo(tmo));
  dcsm_word_map i_dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_DRV(drv),
    .I_OUT_FREQ(ofreq), .I_OUT_NEG(oneg), .I_OUT_CURRENT(cur), .I_DIN(din), .O_CMD(cmd), .O_FREQ_CMD(fcmd),
    .O_RELAY(relay));
  // ****************
  // bus access and comparison
  // ****************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    i_master.xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] r);
    i_master.xfer(1'b0, a, 16'h0000, r);
  endtask : rd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic trip_pulse();
    drv <= 12'hA00;
    @(posedge clk);
    drv <= 12'h800;
    repeat (2) @(posedge clk);
  endtask : trip_pulse
  // standard bits 15..13 and 11..8, limits 000A/0064, current limit 0400
  function automatic logic [6:0] std_exp(input dcsm_pkg::dcsm_drv_t d, input logic [15:0] f, input logic [15:0] c);
    std_exp = {d.temp_motor | d.temp_conv | d.thermistor, c > 16'h0400, d.volt_low | d.volt_high,
      f != 16'h0000, f > 16'h000A && f < 16'h0064, !(d.local_key || d.local_mode), d.at_speed};
  endfunction : std_exp
  always @(posedge clk) begin
    if (tmo === 1'b1) begin
      n_fail++;
      close_out();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [15:0] r;
    logic [15:0] ctl [6] = '{16'h0507, 16'h0607, 16'h0407, 16'h0C07, 16'h1407, 16'h1C07};
    logic [15:0] fexp [6] = '{16'h0111, 16'h0222, 16'h0032, 16'h0019, 16'h004B, 16'h0019};
    void'($urandom(96408));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h10, r);
    chk(r, 16'h0001);
    rd(8'h3C, r);
    chk(r, 16'h0000);
    wr(8'h20, 16'h000A);
    wr(8'h24, 16'h0064);
    wr(8'h30, 16'h0400);
    for (int i = 0; i < 40; i++) begin
      // second half runs profile 3, which must look standard
      if (i == 20) wr(8'h10, 16'h0003);
      drv <= 12'($urandom) & 12'hDFF;
      ofreq <= 16'($urandom_range(120));
      cur <= 16'($urandom_range(2047));
      rd(8'h04, st);
      chk({st[15:13], st[11:8]}, std_exp(drv, ofreq, cur));
    end
    wr(8'h10, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      din <= 5'($urandom);
      repeat (3) @(posedge clk);
      rd(8'h04, st);
      chk({st[15:12], st[5]}, din);
    end
    drv <= 12'h800;
    cur <= 16'h0000;
    ofreq <= 16'h0000;
    wr(8'h10, 16'h0004);
    rd(8'h04, st);
    chk(st[6], 1'b1);
    for (int k = 0; k < 16; k++) begin
      wr(8'h00, 16'h0400 | 16'(k));
      rd(8'h04, st);
      chk({st[5:4], st[2], st[0]}, {~k[2], ~k[1], &k[3:0], &k[2:0]});
    end
    wr(8'h00, 16'h0406);
    rd(8'h04, st);
    chk({st[6], relay, cmd.ramp_stop}, 3'b011);
    wr(8'h00, 16'h047F);
    rd(8'h04, st);
    chk({cmd.start, relay, st[11]}, 3'b101);
    wr(8'h00, 16'h0405);
    rd(8'h04, st);
    chk(st[6], 1'b1);
    wr(8'h14, 16'h0111);
    wr(8'h18, 16'h0222);
    wr(8'h1C, 16'h1000);
    wr(8'h2C, 16'h0064);
    wr(8'h08, 16'h2000);
    for (int k = 0; k < 6; k++) begin
      wr(8'h00, ctl[k]);
      @(posedge clk);
      chk(fcmd, fexp[k]);
    end
    wr(8'h00, 16'h0407);
    wr(8'h08, 16'hE000);
    @(posedge clk);
    chk({cmd.reverse, fcmd}, 17'h10032);
    wr(8'h20, 16'h0000);
    wr(8'h24, 16'h0032);
    ofreq <= 16'h0019;
    rd(8'h0C, r);
    chk(r, 16'h2000);
    ofreq <= 16'h0064;
    rd(8'h0C, r);
    chk(r, 16'h7FFF);
    oneg <= 1'b1;
    ofreq <= 16'h0019;
    rd(8'h0C, r);
    chk(r, 16'hE000);
    wr(8'h00, 16'h0007);
    drv <= 12'h802;
    wr(8'h00, 16'h0400);
    drv <= 12'h800;
    rd(8'h00, r);
    chk(r, 16'h0407);
    trip_pulse();
    chk(cmd.trip, 1'b1);
    wr(8'h00, 16'h0487);
    @(posedge clk);
    chk(cmd.trip, 1'b0);
    trip_pulse();
    wr(8'h00, 16'h0487);
    @(posedge clk);
    chk(cmd.trip, 1'b1);
    wr(8'h00, 16'h0407);
    wr(8'h00, 16'h0487);
    wr(8'h34, 16'h0010);
    cur <= 16'h0500;
    repeat (30) @(posedge clk);
    chk(cmd.trip, 1'b1);
    close_out();
  end
endmodule : drive_control_status_word_map_test
`default_nettype wire
